// ==== src/asp_map.vh ====
// Register map, field layout and reset values of the analog-shared input ports.
// Assumes a byte-addressed view of 32-bit registers at byte offsets below.
`ifndef ASP_MAP_VH
`define ASP_MAP_VH

// Bus geometry
`define ASP_ADDR_W 8
`define ASP_DATA_W 32

// 8-bit port register offsets
`define ASP_P8_LEVELS_OFS 8'h00
`define ASP_P8_FSEL_OFS 8'h08
`define ASP_P8_PULLUP_OFS 8'h2c
`define ASP_P8_INEN_OFS 8'h38

// 4-bit port register offsets, placed in a second window
`define ASP_P4_LEVELS_OFS 8'h40
`define ASP_P4_PULLUP_OFS 8'h6c
`define ASP_P4_INEN_OFS 8'h78

// Port widths and function-select width
`define ASP_P4_W 4
`define ASP_P8_W 8
`define ASP_FSEL_W 4

// Reset values
`define ASP_P4_LEVELS_RST 4'hf
`define ASP_P8_LEVELS_RST 8'hff
`define ASP_P4_CTRL_RST 4'h0
`define ASP_P8_CTRL_RST 8'h00
`define ASP_FSEL_RST 4'h0

// Function-select bit positions
`define ASP_FSEL_T5IN0 0
`define ASP_FSEL_T5IN1 1
`define ASP_FSEL_T6IN0 2
`define ASP_FSEL_T6IN1 3

// Level read on a pin whose input path is closed
`define ASP_CLOSED_LEVEL 1'b1

`endif

// ==== src/asp_input_ports.v ====
// Two input-only pin ports (4 and 8 bits) shared with converter and timer inputs,
// with their pull-up and input-enable registers and the 8-bit port's function-select register.
// Also holds the two-flop synchroniser shared by both pin groups.
// Assumes a single-cycle register port on core_clk and raw asynchronous pins.
`timescale 1ns/1ps
`include "asp_map.vh"

module asp_input_ports #(
	parameter P4_W = `ASP_P4_W,
	parameter P8_W = `ASP_P8_W
) (
	core_clk,
	rstn,
	regAddr,
	regWdata,
	regWrite,
	regRead,
	regRdata,
	port4Pins,
	port8Pins,
	port4PullupBits,
	port4InputBits,
	port8PullupBits,
	port8InputBits,
	port4AnalogReady,
	port8AnalogReady,
	timerFiveInputZero,
	timerFiveInputOne,
	timerSixInputZero,
	timerSixInputOne
);
	input wire core_clk;
	input wire rstn;
	input wire [`ASP_ADDR_W-1:0] regAddr;
	input wire [`ASP_DATA_W-1:0] regWdata;
	input wire regWrite;
	input wire regRead;
	output wire [`ASP_DATA_W-1:0] regRdata;
	input wire [P4_W-1:0] port4Pins;
	input wire [P8_W-1:0] port8Pins;
	output wire [P4_W-1:0] port4PullupBits;
	output wire [P4_W-1:0] port4InputBits;
	output wire [P8_W-1:0] port8PullupBits;
	output wire [P8_W-1:0] port8InputBits;
	output wire [P4_W-1:0] port4AnalogReady;
	output wire [P8_W-1:0] port8AnalogReady;
	output wire timerFiveInputZero;
	output wire timerFiveInputOne;
	output wire timerSixInputZero;
	output wire timerSixInputOne;

	// Control registers
	reg [P4_W-1:0] port4Pullup_reg;
	reg [P4_W-1:0] port4Inen_reg;
	reg [P8_W-1:0] port8Pullup_reg;
	reg [P8_W-1:0] port8Inen_reg;
	reg [`ASP_FSEL_W-1:0] port8Fsel_reg;

	// Next values of the control registers
	reg [P4_W-1:0] port4Pullup_next;
	reg [P4_W-1:0] port4Inen_next;
	reg [P8_W-1:0] port8Pullup_next;
	reg [P8_W-1:0] port8Inen_next;
	reg [`ASP_FSEL_W-1:0] port8Fsel_next;

	// Analog hand-over status flops and their next values
	reg [P4_W-1:0] port4Analog_reg;
	reg [P4_W-1:0] port4Analog_next;
	reg [P8_W-1:0] port8Analog_reg;
	reg [P8_W-1:0] port8Analog_next;

	// Synchronised pin levels; the raw pins reach nothing else
	wire [P4_W-1:0] port4Sync;
	wire [P8_W-1:0] port8Sync;

	// Timer input flops and read data
	reg [`ASP_FSEL_W-1:0] timerIn_reg;
	reg [`ASP_FSEL_W-1:0] timerIn_next;
	reg [`ASP_DATA_W-1:0] rdata_reg;
	reg [`ASP_DATA_W-1:0] rdata_next;

	// Gated pin levels as software sees them
	wire [P4_W-1:0] port4Levels;
	wire [P8_W-1:0] port8Levels;

	// Write strobes per register
	wire wrP4Pullup;
	wire wrP4Inen;
	wire wrP8Pullup;
	wire wrP8Inen;
	wire wrP8Fsel;

	// Address decode for writes; level registers have no write strobe at all.
	// The full address is compared, so no register answers at an alias and a
	// write to an unmapped offset changes nothing
	assign wrP4Pullup = regWrite && (regAddr == `ASP_P4_PULLUP_OFS);
	assign wrP4Inen = regWrite && (regAddr == `ASP_P4_INEN_OFS);
	assign wrP8Pullup = regWrite && (regAddr == `ASP_P8_PULLUP_OFS);
	assign wrP8Inen = regWrite && (regAddr == `ASP_P8_INEN_OFS);
	assign wrP8Fsel = regWrite && (regAddr == `ASP_P8_FSEL_OFS);

	// Two-flop synchronisers on both pin groups; they reset to the closed level
	// like the level registers, which read all ones out of reset with every input closed
	asp_sync2 #(
		.W(P4_W)
	) asp_sync2_p4_i (
		.core_clk(core_clk),
		.rstn(rstn),
		.rawIn(port4Pins),
		.syncOut(port4Sync)
	);

	// Same synchroniser for the 8-bit group; the four timer pins share it
	asp_sync2 #(
		.W(P8_W)
	) asp_sync2_p8_i (
		.core_clk(core_clk),
		.rstn(rstn),
		.rawIn(port8Pins),
		.syncOut(port8Sync)
	);

	// 4-bit port next values; only the low P4_W bits of write data are kept.
	// Holding the old value is the default, so other writes leave them alone
	always @* begin
		port4Pullup_next = port4Pullup_reg;
		port4Inen_next = port4Inen_reg;
		if (wrP4Pullup) begin
			port4Pullup_next = regWdata[P4_W-1:0];
		end
		if (wrP4Inen) begin
			port4Inen_next = regWdata[P4_W-1:0];
		end
	end

	// 4-bit port control flops
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			port4Pullup_reg <= `ASP_P4_CTRL_RST;
			port4Inen_reg <= `ASP_P4_CTRL_RST;
		end else begin
			port4Pullup_reg <= port4Pullup_next;
			port4Inen_reg <= port4Inen_next;
		end
	end

	// 8-bit port next values; reserved upper write bits are dropped.
	// Holding the old value is the default, so other writes leave them alone
	always @* begin
		port8Pullup_next = port8Pullup_reg;
		port8Inen_next = port8Inen_reg;
		port8Fsel_next = port8Fsel_reg;
		if (wrP8Pullup) begin
			port8Pullup_next = regWdata[P8_W-1:0];
		end
		if (wrP8Inen) begin
			port8Inen_next = regWdata[P8_W-1:0];
		end
		if (wrP8Fsel) begin
			port8Fsel_next = regWdata[`ASP_FSEL_W-1:0];
		end
	end

	// 8-bit port control flops
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			port8Pullup_reg <= `ASP_P8_CTRL_RST;
			port8Inen_reg <= `ASP_P8_CTRL_RST;
			port8Fsel_reg <= `ASP_FSEL_RST;
		end else begin
			port8Pullup_reg <= port8Pullup_next;
			port8Inen_reg <= port8Inen_next;
			port8Fsel_reg <= port8Fsel_next;
		end
	end

	// A closed input path reads high, so the level registers show all ones after
	// reset; this also keeps floating analog pins from toggling digital logic.
	// The synchronisers run whether or not a path is open, so opening an input
	// shows the present pin level at once
	assign port4Levels = (port4Sync & port4Inen_reg) | ~port4Inen_reg;
	assign port8Levels = (port8Sync & port8Inen_reg) | ~port8Inen_reg;

	// Timer routing: a pin reaches its timer only with function and input both on;
	// otherwise the timer sees a steady low, never a stale pin value. Gating by the
	// input enable also keeps a pin handed to the converter from clocking a capture
	always @* begin
		timerIn_next = {`ASP_FSEL_W{1'b0}};
		timerIn_next[`ASP_FSEL_T5IN0] = port8Fsel_reg[`ASP_FSEL_T5IN0]
			& port8Inen_reg[`ASP_FSEL_T5IN0] & port8Sync[`ASP_FSEL_T5IN0];
		timerIn_next[`ASP_FSEL_T5IN1] = port8Fsel_reg[`ASP_FSEL_T5IN1]
			& port8Inen_reg[`ASP_FSEL_T5IN1] & port8Sync[`ASP_FSEL_T5IN1];
		timerIn_next[`ASP_FSEL_T6IN0] = port8Fsel_reg[`ASP_FSEL_T6IN0]
			& port8Inen_reg[`ASP_FSEL_T6IN0] & port8Sync[`ASP_FSEL_T6IN0];
		timerIn_next[`ASP_FSEL_T6IN1] = port8Fsel_reg[`ASP_FSEL_T6IN1]
			& port8Inen_reg[`ASP_FSEL_T6IN1] & port8Sync[`ASP_FSEL_T6IN1];
	end

	// Timer inputs come from flops, one cycle behind the synchroniser.
	// This costs a cycle of latency but gives the capture units a glitch-free input
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			timerIn_reg <= {`ASP_FSEL_W{1'b0}};
		end else begin
			timerIn_reg <= timerIn_next;
		end
	end

	// Read mux; unmapped addresses and reserved bits return zero.
	// The mux is gated by the read strobe, so the data flop below clears itself
	// in every cycle that follows no read
	always @* begin
		rdata_next = {`ASP_DATA_W{1'b0}};
		if (regRead) begin
			case (regAddr)
				`ASP_P8_LEVELS_OFS: begin
					rdata_next[P8_W-1:0] = port8Levels;
				end
				`ASP_P8_FSEL_OFS: begin
					rdata_next[`ASP_FSEL_W-1:0] = port8Fsel_reg;
				end
				`ASP_P8_PULLUP_OFS: begin
					rdata_next[P8_W-1:0] = port8Pullup_reg;
				end
				`ASP_P8_INEN_OFS: begin
					rdata_next[P8_W-1:0] = port8Inen_reg;
				end
				`ASP_P4_LEVELS_OFS: begin
					rdata_next[P4_W-1:0] = port4Levels;
				end
				`ASP_P4_PULLUP_OFS: begin
					rdata_next[P4_W-1:0] = port4Pullup_reg;
				end
				`ASP_P4_INEN_OFS: begin
					rdata_next[P4_W-1:0] = port4Inen_reg;
				end
				default: begin
					rdata_next = {`ASP_DATA_W{1'b0}};
				end
			endcase
		end
	end

	// Read data stands only in the cycle after the strobe, zero otherwise.
	// Clearing between reads keeps stale register contents off the shared bus
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			rdata_reg <= {`ASP_DATA_W{1'b0}};
		end else begin
			rdata_reg <= rdata_next;
		end
	end

	// Pad controls straight from the registers
	// Flop outputs, so the pad drivers see no decode glitches
	assign port4PullupBits = port4Pullup_reg;
	assign port4InputBits = port4Inen_reg;
	assign port8PullupBits = port8Pullup_reg;
	assign port8InputBits = port8Inen_reg;

	// Status only: software still owns the analog hand-over, this just shows
	// which pins are fully released from the digital path. Built from the next
	// values so it changes on the same edge as the control outputs it follows
	always @* begin
		port4Analog_next = ~port4Inen_next & ~port4Pullup_next;
		port8Analog_next = ~port8Inen_next & ~port8Pullup_next;
	end

	// Analog status flops; every pin reads as released while in reset
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			port4Analog_reg <= ~`ASP_P4_CTRL_RST;
			port8Analog_reg <= ~`ASP_P8_CTRL_RST;
		end else begin
			port4Analog_reg <= port4Analog_next;
			port8Analog_reg <= port8Analog_next;
		end
	end

	assign port4AnalogReady = port4Analog_reg;
	assign port8AnalogReady = port8Analog_reg;

	// Timer outputs, one per function-select bit position
	assign timerFiveInputZero = timerIn_reg[`ASP_FSEL_T5IN0];
	assign timerFiveInputOne = timerIn_reg[`ASP_FSEL_T5IN1];
	assign timerSixInputZero = timerIn_reg[`ASP_FSEL_T6IN0];
	assign timerSixInputOne = timerIn_reg[`ASP_FSEL_T6IN1];

	// Read data straight from its flop
	assign regRdata = rdata_reg;

endmodule // asp_input_ports

// Two-flop synchroniser for a group of asynchronous pins. Only the second
// stage is visible outside. Bits are synchronised one by one, so a pattern
// that changes on several pins at once may be seen split across two cycles;
// the pins here are independent inputs, so that is acceptable. Both stages
// reset to a chosen level so the first reads after reset are predictable.
module asp_sync2 #(
	parameter W = 1,
	parameter [0:0] RST_LEVEL = `ASP_CLOSED_LEVEL
) (
	core_clk,
	rstn,
	rawIn,
	syncOut
);
	// Clock, reset and the raw and synchronised pin groups
	input wire core_clk;
	input wire rstn;
	input wire [W-1:0] rawIn;
	output wire [W-1:0] syncOut;

	// First stage may go metastable; nothing but the second stage reads it
	reg [W-1:0] meta_reg;
	reg [W-1:0] sync_reg;

	// Both stages shift on every edge; reset loads the chosen level
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			meta_reg <= {W{RST_LEVEL}};
			sync_reg <= {W{RST_LEVEL}};
		end else begin
			meta_reg <= rawIn;
			sync_reg <= meta_reg;
		end
	end

	// Only the settled stage leaves the module
	assign syncOut = sync_reg;

endmodule // asp_sync2

// ==== testbench/asp_input_ports_sva.sv ====
// Concurrent checks on the ports of the analog-shared input ports block.
// Assumes default widths: 4-bit and 8-bit ports, 8-bit address, 32-bit data.
`timescale 1ns/1ps
module asp_input_ports_sva (
	input wire core_clk,
	input wire rstn,
	input wire [7:0] regAddr,
	input wire [31:0] regWdata,
	input wire regWrite,
	input wire regRead,
	input wire [31:0] regRdata,
	input wire [3:0] port4PullupBits,
	input wire [3:0] port4InputBits,
	input wire [7:0] port8PullupBits,
	input wire [7:0] port8InputBits,
	input wire [7:0] port8AnalogReady,
	input wire timerFiveInputZero
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rstn);
	// Read data stands only in the cycle after a read
	property p_rdzero; !$past(regRead) |-> regRdata == 32'h0; endproperty
	a_rdzero: assert property (p_rdzero) else $error("read data outside slot");
	property p_ie4; regWrite && regAddr == 8'h78 |=> port4InputBits == $past(regWdata[3:0]); endproperty
	a_ie4: assert property (p_ie4) else $error("4-bit input enable write lost");
	property p_ie8; regWrite && regAddr == 8'h38 |=> port8InputBits == $past(regWdata[7:0]); endproperty
	a_ie8: assert property (p_ie8) else $error("8-bit input enable write lost");
	property p_pu8; regWrite && regAddr == 8'h2c |=> port8PullupBits == $past(regWdata[7:0]); endproperty
	a_pu8: assert property (p_pu8) else $error("8-bit pull-up write lost");
	property p_pu4rd; regRead && regAddr == 8'h6c |=> regRdata == {28'h0, $past(port4PullupBits)};
	endproperty
	a_pu4rd: assert property (p_pu4rd) else $error("4-bit pull-up readback wrong");
	property p_lv4; regRead && regAddr == 8'h40 |=> regRdata[31:4] == 28'h0; endproperty
	a_lv4: assert property (p_lv4) else $error("4-bit level upper bits set");
	property p_lv8; regRead && regAddr == 8'h00 |=> regRdata[31:8] == 24'h0; endproperty
	a_lv8: assert property (p_lv8) else $error("8-bit level upper bits set");
	property p_ana; port8AnalogReady == ~(port8InputBits | port8PullupBits); endproperty
	a_ana: assert property (p_ana) else $error("analog ready wrong");
	property p_tmr; timerFiveInputZero |-> $past(port8InputBits[0]); endproperty
	a_tmr: assert property (p_tmr) else $error("timer fed with input closed");
	c_wr: cover property (regWrite && regAddr == 8'h08);
	c_rd: cover property (regRead ##1 regRdata != 32'h0);
	c_tmr: cover property (timerFiveInputZero);
endmodule // asp_input_ports_sva

// ==== testbench/asp_pin_model.sv ====
// Board-side pins of both ports: driven levels or floating lines.
// Assumes bits 3-0 are the 4-bit port and bits 11-4 the 8-bit port.
`timescale 1ns/1ps
module asp_pin_model (
	input wire core_clk,
	input wire [11:0] drv,
	input wire [11:0] flt,
	input wire [11:0] pup,
	output wire [11:0] pins
);
	logic tgl = 1'b0;
	always @(posedge core_clk) begin
		tgl <= ~tgl;
	end
	// A floating pin without pull-up wanders so a stale level never passes
	assign pins = (drv & ~flt) | (flt & (pup | {12{tgl}}));
endmodule // asp_pin_model

// ==== testbench/tb.sv ====
// Register and pin tests of the analog-shared input ports block.
// Assumes the block sees only this bench and the pin model.
`timescale 1ns/1ps
module tb;
	logic core_clk = 1'b0;
	logic rstn = 1'b0;
	logic [7:0] regAddr = 8'h00;
	logic [31:0] regWdata = 32'h0;
	logic regWrite = 1'b0;
	logic regRead = 1'b0;
	logic [11:0] drv = 12'h000;
	logic [11:0] flt = 12'h000;
	wire [31:0] regRdata;
	wire [11:0] pins;
	wire [3:0] pu4, ie4, ar4, tmr;
	wire [7:0] pu8, ie8, ar8;
	int nErrors = 0;
	int checksDone = 0;
	logic [7:0] adr [5] = '{8'h08, 8'h2c, 8'h38, 8'h6c, 8'h78};
	logic [31:0] msk [5] = '{32'hf, 32'hff, 32'hff, 32'hf, 32'hf};
	always #2 core_clk = ~core_clk;
	asp_input_ports asp_input_ports_i (.core_clk(core_clk), .rstn(rstn), .regAddr(regAddr),
		.regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
		.port4Pins(pins[3:0]), .port8Pins(pins[11:4]), .port4PullupBits(pu4),
		.port4InputBits(ie4), .port8PullupBits(pu8), .port8InputBits(ie8),
		.port4AnalogReady(ar4), .port8AnalogReady(ar8), .timerFiveInputZero(tmr[0]),
		.timerFiveInputOne(tmr[1]), .timerSixInputZero(tmr[2]), .timerSixInputOne(tmr[3]));
	asp_pin_model asp_pin_model_i (.core_clk(core_clk), .drv(drv), .flt(flt),
		.pup({pu8, pu4}), .pins(pins));
	task automatic finishTest();
		$display("checks %0d errors %0d", checksDone, nErrors);
		if (nErrors == 0 && checksDone > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
		checksDone++;
		if (seen !== exp) begin
			nErrors++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// Waits land just past the edge so outputs have settled
	task automatic tk(int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task automatic wr(logic [7:0] a, logic [31:0] d);
		@(posedge core_clk);
		regAddr <= a;
		regWdata <= d;
		regWrite <= 1'b1;
		@(posedge core_clk);
		regWrite <= 1'b0;
	endtask
	task automatic rd(logic [7:0] a, logic [31:0] exp);
		@(posedge core_clk);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge core_clk);
		regRead <= 1'b0;
		#1;
		chk("regRdata", regRdata, exp);
	endtask
	initial begin
		#100000;
		nErrors++;
		finishTest();
	end
	initial begin
		repeat (3) @(posedge core_clk);
		rstn <= 1'b1;
		foreach (adr[i]) rd(adr[i], 32'h0);
		rd(8'h00, 32'hff);
		rd(8'h40, 32'hf);
		rd(8'h04, 32'h0);
		// Reserved bits must drop, each bit must store on its own
		foreach (adr[i]) begin
			wr(adr[i], 32'hffffffff);
			rd(adr[i], msk[i]);
			wr(adr[i], 32'hffffff5a);
			rd(adr[i], msk[i] & 32'h5a);
		end
		chk("port4AnalogReady", {28'h0, ar4}, 32'h5);
		wr(8'h2c, 32'h0);
		wr(8'h6c, 32'h0);
		wr(8'h38, 32'hff);
		wr(8'h78, 32'hf);
		wr(8'h08, 32'hf);
		@(posedge core_clk);
		drv <= 12'h969;
		tk(4);
		rd(8'h00, 32'h96);
		rd(8'h40, 32'h9);
		chk("timers", {28'h0, tmr}, 32'h6);
		wr(8'h00, 32'h0);
		rd(8'h00, 32'h96);
		@(posedge core_clk);
		drv <= 12'h690;
		tk(4);
		chk("timers", {28'h0, tmr}, 32'h9);
		wr(8'h38, 32'hf0);
		tk(2);
		chk("timers", {28'h0, tmr}, 32'h0);
		rd(8'h00, 32'h6f);
		wr(8'h38, 32'hff);
		wr(8'h08, 32'h0);
		tk(4);
		chk("timers", {28'h0, tmr}, 32'h0);
		@(posedge core_clk);
		flt <= 12'hfff;
		wr(8'h2c, 32'hff);
		tk(4);
		rd(8'h00, 32'hff);
		// Analog use: software closes input and pull-up first
		wr(8'h38, 32'h0);
		wr(8'h2c, 32'h0);
		wr(8'h78, 32'h0);
		tk(1);
		chk("port8AnalogReady", {24'h0, ar8}, 32'hff);
		chk("port4AnalogReady", {28'h0, ar4}, 32'hf);
		// Open inputs again so the mid-run reset has something to clear
		wr(8'h38, 32'hff);
		wr(8'h78, 32'hf);
		@(posedge core_clk);
		rstn <= 1'b0;
		@(posedge core_clk);
		rstn <= 1'b1;
		rd(8'h38, 32'h0);
		rd(8'h00, 32'hff);
		chk("port4InputBits", {28'h0, ie4}, 32'h0);
		chk("port8InputBits", {24'h0, ie8}, 32'h0);
		chk("port4AnalogReady", {28'h0, ar4}, 32'hf);
		finishTest();
	end
endmodule // tb
bind asp_input_ports asp_input_ports_sva asp_input_ports_sva_i (.core_clk(core_clk),
	.rstn(rstn), .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
	.regRead(regRead), .regRdata(regRdata), .port4PullupBits(port4PullupBits),
	.port4InputBits(port4InputBits), .port8PullupBits(port8PullupBits),
	.port8InputBits(port8InputBits), .port8AnalogReady(port8AnalogReady),
	.timerFiveInputZero(timerFiveInputZero));
